// file: rtl/assc_cfg.svh
`ifndef ASSC_CFG_SVH
`define ASSC_CFG_SVH

// register byte offsets
`define ASSC_OFS_CTRL1 8'h00
`define ASSC_OFS_CTRL2 8'h04
`define ASSC_OFS_CTRL3 8'h08
`define ASSC_OFS_STAT1 8'h0c
`define ASSC_OFS_STAT2 8'h10
`define ASSC_OFS_DATA 8'h14

// first control register fields
`define ASSC_C1_EN 0
`define ASSC_C1_M9 1
`define ASSC_C1_WAKE 2
`define ASSC_C1_PEN 3
`define ASSC_C1_PODD 4

// second_control_reg fields
`define ASSC_C2_TIE 7
`define ASSC_C2_TX_COMPLETE_IRQ_EN 6
`define ASSC_C2_RIE 5
`define ASSC_C2_IDLE_IRQ_EN 4
`define ASSC_C2_TE 3
`define ASSC_C2_RE 2
`define ASSC_C2_RWU 1
`define ASSC_C2_SBK 0

// ninth_bit_and_error_irq_ctrl fields, error enables sit at [3:0]
`define ASSC_C3_R8 7
`define ASSC_C3_T8 6

// primary_line_status fields
`define ASSC_S1_TDRE 7
`define ASSC_S1_TC 6
`define ASSC_S1_RDRF 5
`define ASSC_S1_IDLE 4
`define ASSC_S1_OVR 3
`define ASSC_S1_NF 2
`define ASSC_S1_FE 1
`define ASSC_S1_PE 0

// secondary_line_status fields
`define ASSC_S2_BKF 1
`define ASSC_S2_RBUSY 0

// reset values and frame lengths
`define ASSC_STAT1_RST 8'hc0
`define ASSC_CHAR8_BITS 4'ha
`define ASSC_CHAR9_BITS 4'hb
`define ASSC_CLKS_PER_BIT 16

`endif

// file: rtl/assc_pkg.sv
package assc_pkg;

	// transmitter sequencer, one-hot
	typedef enum logic [6:0] {
		TX_IDLE = 7'h01,
		TX_PRE = 7'h02,
		TX_START = 7'h04,
		TX_DATA = 7'h08,
		TX_STOP = 7'h10,
		TX_BRK = 7'h20,
		TX_MARK = 7'h40
	} assc_tx_t;

	// receiver sequencer, one-hot
	typedef enum logic [3:0] {
		RX_IDLE = 4'h1,
		RX_START = 4'h2,
		RX_DATA = 4'h4,
		RX_STOP = 4'h8
	} assc_rx_t;

endpackage

// file: rtl/assc_bit_timer.sv
`timescale 1ns/1ps
module assc_bit_timer #(
	parameter int CLKS = 16,
	localparam int CW = $clog2(CLKS)
) (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic ce,
	input wire logic hold,
	output logic [CW-1:0] count,
	output logic bit_end
);
	localparam logic [CW-1:0] LAST = CW'(CLKS - 1);

	typedef struct packed {
		logic [CW-1:0] cnt;
	} assc_tmr_t;

	assc_tmr_t st;
	assc_tmr_t next_st;

	if (CLKS < 4) begin : g_chk
		$error("bit timer needs at least four clocks per bit");
	end

	// held at zero so the first bit after release is a full period
	always_comb begin
		next_st = st;
		if (hold || st.cnt == LAST) begin
			next_st.cnt = '0;
		end else begin
			next_st.cnt = st.cnt + 1'b1;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			st <= '0;
		end else if (ce) begin
			st <= next_st;
		end
	end

	assign count = st.cnt;
	assign bit_end = !hold && st.cnt == LAST;
endmodule

// file: rtl/assc_status_ctrl.sv
`timescale 1ns/1ps
`include "assc_cfg.svh"
module assc_status_ctrl #(
	parameter int CLKS_PER_BIT = `ASSC_CLKS_PER_BIT,
	parameter int ADDR_W = 8
) (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic ce,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic rxd,
	output logic txd,
	output logic tx_irq_req,
	output logic rx_irq_req,
	output logic err_irq_req
);
	localparam int CW = $clog2(CLKS_PER_BIT);
	localparam int IW = $clog2(11 * CLKS_PER_BIT + 1);
	// the timer starts one clock after the line falls, so the window sits one count early
	localparam logic [CW-1:0] HALF = CW'(CLKS_PER_BIT / 2 - 1);

	typedef struct packed {
		logic [4:0] c1;
		logic [7:0] c2;
		logic [7:0] c3;
		logic [7:0] s1;
		logic break_detect_flag;
		logic [7:0] seen;
		logic seen_bk;
		logic [7:0] tdr;
		logic [7:0] rdr;
		logic [31:0] prdata;
		assc_pkg::assc_tx_t tst;
		logic [8:0] tsh;
		logic [3:0] tbit;
		logic pre_pend;
		logic te_q;
		logic txd;
		assc_pkg::assc_rx_t rxs;
		logic [8:0] rsh;
		logic [3:0] rbit;
		logic [1:0] smp;
		logic nz;
		logic re_q;
		logic idle_arm;
		logic bk_arm;
		logic [IW-1:0] icnt;
	} assc_state_t;

	localparam assc_state_t RST_ST = '{tst: assc_pkg::TX_IDLE, rxs: assc_pkg::RX_IDLE,
		s1: `ASSC_STAT1_RST, txd: 1'b1, default: '0};

	assc_state_t st;
	assc_state_t next_st;
	logic acc, wr, rd, hit, en, m9;
	logic [3:0] nbits, clen;
	logic [IW-1:0] idle_lim;
	logic [CW-1:0] rcount;
	logic tend, rend;
	logic rx_done, rx_brk, rx_load, idle_hit, maj, noisy, par;
	logic [7:0] d8;

	if (CLKS_PER_BIT < 4 || ADDR_W < 5) begin : g_chk
		$error("clocks per bit below four or address too narrow");
	end

	// one timer per direction, each held while its sequencer idles
	assc_bit_timer #(.CLKS(CLKS_PER_BIT)) u_tx_tmr (
		.ref_clk(ref_clk),
		.rst(rst),
		.ce(ce),
		.hold(st.tst == assc_pkg::TX_IDLE),
		.count(),
		.bit_end(tend)
	);

	assc_bit_timer #(.CLKS(CLKS_PER_BIT)) u_rx_tmr (
		.ref_clk(ref_clk),
		.rst(rst),
		.ce(ce),
		.hold(st.rxs == assc_pkg::RX_IDLE),
		.count(rcount),
		.bit_end(rend)
	);

	// bus decode and format selections
	assign acc = psel && penable;
	assign wr = acc && pwrite;
	assign rd = acc && !pwrite;
	assign hit = paddr[ADDR_W-1:0] <= ADDR_W'(`ASSC_OFS_DATA) && paddr[1:0] == 2'b00;
	assign en = st.c1[`ASSC_C1_EN];
	assign m9 = st.c1[`ASSC_C1_M9];
	assign nbits = m9 ? 4'h9 : 4'h8;
	assign clen = m9 ? `ASSC_CHAR9_BITS : `ASSC_CHAR8_BITS;
	assign idle_lim = IW'(clen * CLKS_PER_BIT);
	// three samples around mid-bit, majority decides, any split is noise
	assign maj = (st.smp[0] & st.smp[1]) | (st.smp[0] & rxd) | (st.smp[1] & rxd);
	assign noisy = !(st.smp[0] == st.smp[1] && st.smp[1] == rxd);
	assign d8 = m9 ? st.rsh[7:0] : st.rsh[8:1];
	assign par = ^(m9 ? st.rsh : {1'b0, st.rsh[8:1]}) ^ st.c1[`ASSC_C1_PODD];

	always_comb begin
		next_st = st;
		rx_done = 1'b0;
		rx_brk = 1'b0;
		rx_load = 1'b0;
		idle_hit = 1'b0;

		// setup phase: capture read data so it comes from a flop
		if (psel && !penable) begin
			case (paddr)
				ADDR_W'(`ASSC_OFS_CTRL1): next_st.prdata = {27'h0, st.c1};
				ADDR_W'(`ASSC_OFS_CTRL2): next_st.prdata = {24'h0, st.c2};
				ADDR_W'(`ASSC_OFS_CTRL3): next_st.prdata = {24'h0, st.c3};
				ADDR_W'(`ASSC_OFS_STAT1): next_st.prdata = {24'h0, st.s1};
				ADDR_W'(`ASSC_OFS_STAT2): next_st.prdata = {30'h0, st.break_detect_flag,
					st.rxs != assc_pkg::RX_IDLE};
				ADDR_W'(`ASSC_OFS_DATA): next_st.prdata = {24'h0, st.rdr};
				default: next_st.prdata = 32'h0;
			endcase
		end

		// access phase writes
		if (wr) begin
			case (paddr)
				ADDR_W'(`ASSC_OFS_CTRL1): next_st.c1 = pwdata[4:0];
				ADDR_W'(`ASSC_OFS_CTRL2): begin
					next_st.c2 = pwdata[7:0];
					// enables cannot change while the module is off
					if (!en) begin
						next_st.c2[`ASSC_C2_TE] = st.c2[`ASSC_C2_TE];
						next_st.c2[`ASSC_C2_RE] = st.c2[`ASSC_C2_RE];
					end
				end
				ADDR_W'(`ASSC_OFS_CTRL3): next_st.c3[6:0] = {pwdata[6], 2'b00, pwdata[3:0]};
				ADDR_W'(`ASSC_OFS_DATA): begin
					next_st.tdr = pwdata[7:0];
					if (st.seen[`ASSC_S1_TDRE]) next_st.s1[`ASSC_S1_TDRE] = 1'b0;
					next_st.seen[`ASSC_S1_TDRE] = 1'b0;
				end
				default: ;
			endcase
		end

		// access phase reads: status reads arm, data read clears what was seen in status bits 5:0 and the break flag
		if (rd) begin
			case (paddr)
				ADDR_W'(`ASSC_OFS_STAT1): next_st.seen = st.prdata[7:0];
				ADDR_W'(`ASSC_OFS_STAT2): next_st.seen_bk = st.prdata[`ASSC_S2_BKF];
				ADDR_W'(`ASSC_OFS_DATA): begin
					next_st.s1[5:0] = st.s1[5:0] & ~st.seen[5:0];
					next_st.break_detect_flag = st.break_detect_flag & !st.seen_bk;
					next_st.seen[5:0] = 6'h0;
					next_st.seen_bk = 1'b0;
				end
				default: ;
			endcase
		end

		// transmitter: break wins over preamble, preamble over data
		next_st.te_q = st.c2[`ASSC_C2_TE];
		if (st.c2[`ASSC_C2_TE] && !st.te_q) next_st.pre_pend = 1'b1;
		if (!en) begin
			next_st.tst = assc_pkg::TX_IDLE;
			next_st.pre_pend = 1'b0;
		end else begin
			unique case (st.tst)
				assc_pkg::TX_IDLE: begin
					next_st.tbit = 4'h0;
					if (st.c2[`ASSC_C2_TE]) begin
						if (st.c2[`ASSC_C2_SBK]) begin
							next_st.tst = assc_pkg::TX_BRK;
							next_st.pre_pend = 1'b0;
						end else if (st.pre_pend) begin
							next_st.tst = assc_pkg::TX_PRE;
							next_st.pre_pend = 1'b0;
						end else if (!st.s1[`ASSC_S1_TDRE]) begin
							// ninth bit or parity rides with the data
							if (m9) begin
								next_st.tsh = {st.c1[`ASSC_C1_PEN] ? ^st.tdr ^ st.c1[`ASSC_C1_PODD]
									: st.c3[`ASSC_C3_T8], st.tdr};
							end else begin
								next_st.tsh = {1'b0, st.c1[`ASSC_C1_PEN] ?
									^st.tdr[6:0] ^ st.c1[`ASSC_C1_PODD] : st.tdr[7], st.tdr[6:0]};
							end
							next_st.s1[`ASSC_S1_TDRE] = 1'b1;
							next_st.tst = assc_pkg::TX_START;
						end
					end
				end
				assc_pkg::TX_PRE: if (tend) begin
					if (st.tbit == clen - 4'h1) next_st.tst = assc_pkg::TX_IDLE;
					else next_st.tbit = st.tbit + 4'h1;
				end
				assc_pkg::TX_START: if (tend) next_st.tst = assc_pkg::TX_DATA;
				assc_pkg::TX_DATA: if (tend) begin
					next_st.tsh = st.tsh >> 1;
					if (st.tbit == nbits - 4'h1) next_st.tst = assc_pkg::TX_STOP;
					else next_st.tbit = st.tbit + 4'h1;
				end
				assc_pkg::TX_STOP: if (tend) next_st.tst = assc_pkg::TX_IDLE;
				assc_pkg::TX_BRK: if (tend) begin
					// zeros for the full frame; held control repeats with no gap
					if (st.tbit == clen - 4'h1) begin
						next_st.tbit = 4'h0;
						if (!st.c2[`ASSC_C2_SBK]) next_st.tst = assc_pkg::TX_MARK;
					end else begin
						next_st.tbit = st.tbit + 4'h1;
					end
				end
				assc_pkg::TX_MARK: if (tend) next_st.tst = assc_pkg::TX_IDLE;
				default: next_st.tst = assc_pkg::TX_IDLE;
			endcase
		end
		next_st.txd = !(next_st.tst == assc_pkg::TX_START || next_st.tst == assc_pkg::TX_BRK)
			&& (next_st.tst != assc_pkg::TX_DATA || next_st.tsh[0]);
		// disabled module forces both transmit flags
		if (!en) next_st.s1[`ASSC_S1_TDRE] = 1'b1;
		next_st.s1[`ASSC_S1_TC] = !en || (next_st.s1[`ASSC_S1_TDRE] && !next_st.pre_pend
			&& next_st.tst == assc_pkg::TX_IDLE
			&& !(st.c2[`ASSC_C2_TE] && st.c2[`ASSC_C2_SBK]));

		// receiver sampling
		next_st.re_q = st.c2[`ASSC_C2_RE];
		if (st.c2[`ASSC_C2_RE] && !st.re_q) next_st.idle_arm = 1'b0;
		if (rcount == HALF - 1'b1) next_st.smp[0] = rxd;
		if (rcount == HALF) next_st.smp[1] = rxd;
		if (!en || !st.c2[`ASSC_C2_RE]) begin
			next_st.rxs = assc_pkg::RX_IDLE;
			next_st.icnt = '0;
		end else begin
			unique case (st.rxs)
				assc_pkg::RX_IDLE: begin
					if (!rxd) begin
						next_st.rxs = assc_pkg::RX_START;
						next_st.icnt = '0;
					end else begin
						next_st.bk_arm = 1'b1;
						if (st.icnt != idle_lim) next_st.icnt = st.icnt + 1'b1;
						idle_hit = st.icnt == idle_lim - 1'b1;
					end
				end
				assc_pkg::RX_START: begin
					if (rcount == HALF + 1'b1) begin
						next_st.nz = noisy;
						if (maj) next_st.rxs = assc_pkg::RX_IDLE;
					end
					if (rend) begin
						next_st.rxs = assc_pkg::RX_DATA;
						next_st.rbit = 4'h0;
					end
				end
				assc_pkg::RX_DATA: begin
					if (rcount == HALF + 1'b1) begin
						next_st.rsh = {maj, st.rsh[8:1]};
						next_st.nz = st.nz | noisy;
					end
					if (rend) begin
						if (st.rbit == nbits - 4'h1) next_st.rxs = assc_pkg::RX_STOP;
						else next_st.rbit = st.rbit + 4'h1;
					end
				end
				assc_pkg::RX_STOP: if (rcount == HALF + 1'b1) begin
					rx_done = 1'b1;
					rx_brk = !maj && !(|d8) && !(m9 && st.rsh[8]);
					next_st.rxs = assc_pkg::RX_IDLE;
				end
				default: next_st.rxs = assc_pkg::RX_IDLE;
			endcase
		end

		// idle line: flag only once armed, and it may wake the receiver
		if (idle_hit) begin
			if (st.idle_arm) begin
				next_st.s1[`ASSC_S1_IDLE] = 1'b1;
				next_st.idle_arm = 1'b0;
			end
			if (!st.c1[`ASSC_C1_WAKE]) next_st.c2[`ASSC_C2_RWU] = 1'b0;
		end

		// character complete; flag sets come after the clears so they win
		if (rx_done) begin
			if (rx_brk) begin
				if (st.bk_arm) next_st.break_detect_flag = 1'b1;
				next_st.bk_arm = 1'b0;
				next_st.s1[`ASSC_S1_FE] = 1'b1;
				next_st.s1[`ASSC_S1_RDRF] = 1'b1;
				next_st.rdr = 8'h00;
				if (m9) next_st.c3[`ASSC_C3_R8] = 1'b0;
			end else if (!st.c2[`ASSC_C2_RWU] || (st.c1[`ASSC_C1_WAKE] && st.rsh[8])) begin
				next_st.c2[`ASSC_C2_RWU] = 1'b0;
				if (next_st.s1[`ASSC_S1_RDRF]) begin
					next_st.s1[`ASSC_S1_OVR] = 1'b1;
				end else begin
					rx_load = 1'b1;
					next_st.rdr = d8;
					next_st.c3[`ASSC_C3_R8] = m9 ? st.rsh[8] : d8[7];
					next_st.s1[`ASSC_S1_RDRF] = 1'b1;
					next_st.idle_arm = 1'b1;
					if (!maj) next_st.s1[`ASSC_S1_FE] = 1'b1;
					if (st.c1[`ASSC_C1_PEN] && par) next_st.s1[`ASSC_S1_PE] = 1'b1;
					if (st.nz || noisy) next_st.s1[`ASSC_S1_NF] = 1'b1;
				end
			end
		end
	end

	// reset leaves both data buffers and the received ninth bit alone
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			st <= RST_ST;
			st.rdr <= st.rdr;
			st.tdr <= st.tdr;
			st.c3[`ASSC_C3_R8] <= st.c3[`ASSC_C3_R8];
		end else if (ce) begin
			st <= next_st;
		end
	end

	assign prdata = st.prdata;
	assign pready = 1'b1;
	assign pslverr = acc && !hit;
	assign txd = st.txd;
	// request lines are gated flop outputs; standby hides receive requests
	assign tx_irq_req = en && ((st.s1[`ASSC_S1_TDRE] && st.c2[`ASSC_C2_TIE])
		|| (st.s1[`ASSC_S1_TC] && st.c2[`ASSC_C2_TX_COMPLETE_IRQ_EN]));
	assign rx_irq_req = !st.c2[`ASSC_C2_RWU] && ((st.s1[`ASSC_S1_RDRF] && st.c2[`ASSC_C2_RIE])
		|| (st.s1[`ASSC_S1_IDLE] && st.c2[`ASSC_C2_IDLE_IRQ_EN]));
	assign err_irq_req = |(st.s1[3:0] & st.c3[3:0]);

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);

	sequence s_data_rd;
		ce && rd && paddr == ADDR_W'(`ASSC_OFS_DATA);
	endsequence

	sequence s_data_wr;
		ce && wr && paddr == ADDR_W'(`ASSC_OFS_DATA);
	endsequence

	a_tdre_clear: assert property (s_data_wr ##0 st.seen[`ASSC_S1_TDRE] && en
		|=> !st.s1[`ASSC_S1_TDRE]) else $error("transmit-empty not cleared");
	a_rdrf_clear: assert property (s_data_rd ##0 st.seen[`ASSC_S1_RDRF] && !rx_done
		|=> !st.s1[`ASSC_S1_RDRF]) else $error("receive-full not cleared");
	a_ovr_kept: assert property (s_data_rd ##0 st.s1[`ASSC_S1_OVR] && !st.seen[`ASSC_S1_OVR]
		|=> st.s1[`ASSC_S1_OVR]) else $error("overrun cleared without seen");
	a_ovr_drop: assert property (ce && rx_done && !rx_brk && !st.c2[`ASSC_C2_RWU]
		&& st.s1[`ASSC_S1_RDRF] && !rd |=> st.s1[`ASSC_S1_OVR] && st.rdr == $past(st.rdr))
		else $error("overrun lost or data changed");
	a_tc_empty: assert property (st.s1[`ASSC_S1_TC] |-> st.s1[`ASSC_S1_TDRE]
		&& (st.tst == assc_pkg::TX_IDLE || !en)) else $error("complete while busy");
	a_off_flags: assert property (ce && !en |=> st.s1[`ASSC_S1_TDRE] && st.s1[`ASSC_S1_TC]
		&& (en || !tx_irq_req)) else $error("disable did not force flags");
	a_brk_low: assert property (st.tst == assc_pkg::TX_BRK |-> !txd)
		else $error("break bit not low");
	a_brk_mark: assert property (ce && st.tst == assc_pkg::TX_BRK && tend
		&& st.tbit == clen - 4'h1 && !st.c2[`ASSC_C2_SBK] && en |=> txd [*4])
		else $error("break end bad");
	a_err_gate: assert property (st.c3[3:0] == 4'h0 |-> !err_irq_req)
		else $error("error request without enable");
	a_brk_flags: assert property (ce && rx_done && rx_brk && st.bk_arm
		|=> st.break_detect_flag && st.s1[`ASSC_S1_FE] && st.s1[`ASSC_S1_RDRF]) else $error("break flags");
	a_idle_wake: assert property (ce && idle_hit && !st.c1[`ASSC_C1_WAKE] && !wr
		|=> !st.c2[`ASSC_C2_RWU]) else $error("idle did not wake");
	a_r8_copy: assert property (ce && rx_load && !m9 |=> st.c3[`ASSC_C3_R8] == st.rdr[7])
		else $error("ninth bit not a copy");
endmodule

// file: testbench/assc_remote_node.sv
`timescale 1ns/1ps
module assc_remote_node #(
	parameter int CLKS = 4
) (
	input wire logic ref_clk,
	input wire logic txd,
	output logic rxd
);
	logic [7:0] got;
	int i;
	// the remote line idles at mark between frames
	initial begin
		rxd = 1'b1;
	end
	// one frame: start 0, data lsb first, then the given stop level (0 with all-zero data makes a break)
	task automatic send(input logic [8:0] v, input int nb, input logic stop);
		int b;
		@(posedge ref_clk);
		for (b = -1; b <= nb; b++) begin
			rxd <= (b < 0) ? 1'b0 : (b < nb) ? v[b] : stop;
			repeat (CLKS) @(posedge ref_clk);
		end
		rxd <= 1'b1;
	endtask
	// capture eight data bits of each frame at mid-bit; a preamble never starts one
	initial begin
		forever begin
			@(negedge txd);
			repeat (CLKS / 2) @(posedge ref_clk);
			for (i = 0; i < 8; i++) begin
				repeat (CLKS) @(posedge ref_clk);
				got[i] = txd;
			end
			repeat (CLKS) @(posedge ref_clk);
		end
	end
endmodule

// file: testbench/async_serial_status_control_bench.sv
`timescale 1ns/1ps
`include "assc_cfg.svh"
module async_serial_status_control_bench;
	localparam int CPB = 4;
	logic ref_clk = 0;
	logic rst = 1;
	logic psel = 0;
	logic penable = 0;
	logic pwrite = 0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic [31:0] q;
	logic pready, pslverr, rxd, txd, tx_irq_req, rx_irq_req, err_irq_req, e;
	int num_errors = 0;
	int n_compared = 0;
	int k;
	int z;

	assc_status_ctrl #(.CLKS_PER_BIT(CPB)) dut(.ref_clk(ref_clk), .rst(rst), .ce(1'b1),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .rxd(rxd), .txd(txd),
		.tx_irq_req(tx_irq_req), .rx_irq_req(rx_irq_req), .err_irq_req(err_irq_req));
	assc_remote_node #(.CLKS(CPB)) node(.ref_clk(ref_clk), .txd(txd), .rxd(rxd));

	initial begin
		forever #10 ref_clk = ~ref_clk;
	end

	task automatic test_done;
		if (num_errors == 0 && n_compared > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	task automatic chk(input string n, input logic [31:0] x, input logic [31:0] s);
		n_compared++;
		if (s !== x) begin
			$display("wrong value %s expected %h seen %h", n, x, s);
			num_errors++;
		end
	endtask
	// one transfer; the request stays put until pready is sampled high
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge ref_clk);
		penable <= 1'b1;
		do @(posedge ref_clk); while (pready !== 1'b1);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		apb(1'b1, a, {24'h0, d});
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] m, input logic [7:0] x, string n);
		apb(1'b0, a, 32'h0);
		chk(n, {24'h0, x}, q & {24'h0, m});
	endtask
	// bounded polling of one status bit; every read is a real status read
	task automatic poll(input logic [7:0] a, input int b);
		k = 0;
		do begin
			apb(1'b0, a, 32'h0);
			k++;
		end while (q[b] !== 1'b1 && k < 100);
		chk("polled flag", 32'h1, {31'h0, q[b]});
	endtask

	// hang guard, far above the thousand or so cycles the sequence needs
	initial begin
		repeat (30000) @(posedge ref_clk);
		num_errors++;
		test_done;
	end

	initial begin
		repeat (3) @(posedge ref_clk);
		rst <= 1'b0;
		rd(`ASSC_OFS_STAT1, 8'hff, 8'hc0, "status reset");
		rd(`ASSC_OFS_CTRL3, 8'h4f, 8'h00, "ctrl3 reset");
		rd(`ASSC_OFS_CTRL2, 8'h01, 8'h00, "break reset");
		apb(1'b0, 8'h1c, 32'h0);
		chk("unmapped error", 32'h1, {31'h0, e});
		wr(`ASSC_OFS_CTRL1, 8'h01);
		wr(`ASSC_OFS_CTRL2, 8'h2c);
		wr(`ASSC_OFS_CTRL3, 8'h4f);
		rd(`ASSC_OFS_CTRL3, 8'h4f, 8'h4f, "ctrl3 rw");
		// transmit one character once the preamble is out
		poll(`ASSC_OFS_STAT1, 6);
		wr(`ASSC_OFS_DATA, 8'ha5);
		rd(`ASSC_OFS_STAT1, 8'h40, 8'h00, "complete cleared");
		poll(`ASSC_OFS_STAT1, 6);
		chk("tx char", 32'h0a5, {24'h0, node.got});
		wr(`ASSC_OFS_CTRL2, 8'hac);
		@(posedge ref_clk);
		chk("tx irq", 32'h1, {31'h0, tx_irq_req});
		// held break, sent long after the empty flag settled
		wr(`ASSC_OFS_CTRL2, 8'h2d);
		repeat (8) @(posedge ref_clk);
		z = 0;
		repeat (80) begin
			@(posedge ref_clk);
			if (txd !== 1'b0) z++;
		end
		chk("break gapless", 32'h0, z);
		wr(`ASSC_OFS_CTRL2, 8'h2c);
		k = 0;
		while (txd !== 1'b1 && k < 60) begin
			@(posedge ref_clk);
			k++;
		end
		z = 0;
		repeat (CPB) begin
			@(posedge ref_clk);
			if (txd !== 1'b1) z++;
		end
		chk("mark after break", 32'h0, z + (k >= 60));
		poll(`ASSC_OFS_STAT1, 6);
		// receive, then let the line go idle
		node.send(9'h096, 8, 1'b1);
		poll(`ASSC_OFS_STAT1, 5);
		chk("rx irq", 32'h1, {31'h0, rx_irq_req});
		rd(`ASSC_OFS_CTRL3, 8'h80, 8'h80, "ninth copy");
		repeat (60) @(posedge ref_clk);
		rd(`ASSC_OFS_STAT1, 8'h30, 8'h30, "idle set");
		rd(`ASSC_OFS_DATA, 8'hff, 8'h96, "rx data");
		repeat (60) @(posedge ref_clk);
		rd(`ASSC_OFS_STAT1, 8'h30, 8'h00, "idle unarmed");
		// overrun arriving after the status read of the clear sequence
		node.send(9'h011, 8, 1'b1);
		poll(`ASSC_OFS_STAT1, 5);
		node.send(9'h022, 8, 1'b1);
		repeat (4) @(posedge ref_clk);
		chk("overrun irq", 32'h1, {31'h0, err_irq_req});
		rd(`ASSC_OFS_DATA, 8'hff, 8'h11, "kept data");
		rd(`ASSC_OFS_STAT1, 8'h08, 8'h08, "overrun held");
		rd(`ASSC_OFS_DATA, 8'hff, 8'h11, "data again");
		rd(`ASSC_OFS_STAT1, 8'h08, 8'h00, "overrun cleared");
		// received break with the framing enable off, then on
		wr(`ASSC_OFS_CTRL3, 8'h0d);
		node.send(9'h000, 8, 1'b0);
		poll(`ASSC_OFS_STAT2, 1);
		rd(`ASSC_OFS_STAT1, 8'h22, 8'h22, "break flags");
		chk("framing masked", 32'h0, {31'h0, err_irq_req});
		wr(`ASSC_OFS_CTRL3, 8'h0f);
		@(posedge ref_clk);
		chk("framing irq", 32'h1, {31'h0, err_irq_req});
		rd(`ASSC_OFS_CTRL3, 8'h80, 8'h00, "break ninth");
		rd(`ASSC_OFS_DATA, 8'hff, 8'h00, "break data");
		rd(`ASSC_OFS_STAT2, 8'h02, 8'h00, "break cleared");
		rd(`ASSC_OFS_STAT1, 8'h22, 8'h00, "framing cleared");
		// standby, address-mark wakeup
		wr(`ASSC_OFS_CTRL1, 8'h05);
		wr(`ASSC_OFS_CTRL2, 8'h2e);
		node.send(9'h005, 8, 1'b1);
		repeat (60) @(posedge ref_clk);
		rd(`ASSC_OFS_CTRL2, 8'h02, 8'h02, "still standby");
		chk("standby irq", 32'h0, {31'h0, rx_irq_req});
		node.send(9'h085, 8, 1'b1);
		poll(`ASSC_OFS_STAT1, 5);
		rd(`ASSC_OFS_CTRL2, 8'h02, 8'h00, "mark wake");
		rd(`ASSC_OFS_DATA, 8'hff, 8'h85, "mark char");
		// standby, idle-line wakeup
		wr(`ASSC_OFS_CTRL1, 8'h01);
		wr(`ASSC_OFS_CTRL2, 8'h2e);
		node.send(9'h055, 8, 1'b1);
		repeat (60) @(posedge ref_clk);
		rd(`ASSC_OFS_CTRL2, 8'h02, 8'h00, "idle wake");
		// nine-bit reception, then a parity mismatch in 8-bit parity mode
		wr(`ASSC_OFS_CTRL1, 8'h03);
		node.send(9'h1a5, 9, 1'b1);
		poll(`ASSC_OFS_STAT1, 5);
		rd(`ASSC_OFS_CTRL3, 8'h80, 8'h80, "ninth bit");
		rd(`ASSC_OFS_DATA, 8'hff, 8'ha5, "nine-bit data");
		wr(`ASSC_OFS_CTRL1, 8'h09);
		node.send(9'h001, 8, 1'b1);
		poll(`ASSC_OFS_STAT1, 5);
		rd(`ASSC_OFS_STAT1, 8'h01, 8'h01, "parity flag");
		chk("parity irq", 32'h1, {31'h0, err_irq_req});
		rd(`ASSC_OFS_DATA, 8'hff, 8'h01, "parity data");
		rd(`ASSC_OFS_STAT1, 8'h01, 8'h00, "parity cleared");
		// module disable forces the transmit flags and masks transmit requests
		wr(`ASSC_OFS_CTRL2, 8'h8c);
		wr(`ASSC_OFS_CTRL1, 8'h00);
		rd(`ASSC_OFS_STAT1, 8'hc0, 8'hc0, "disabled flags");
		chk("disabled irq", 32'h0, {31'h0, tx_irq_req});
		test_done;
	end
endmodule
